// >>> logic/sdt_dma_top.sv
`timescale 1ns/1ps
module sdt_dma_top
    import sdt_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  sfr_page,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata_q,
    input  wire logic        global_engine_irq_enable,
    input  wire logic        ext_irq0_event,
    input  wire logic        ext_irq1_event,
    input  wire logic        ext_irq2_event,
    input  wire logic        keypad_irq_event,
    input  wire logic        timer2_ext_input_sel,
    input  wire logic        timer3_ext_input_sel,
    input  wire logic        count_timer_pin,
    input  wire logic        address_timer_pin,
    input  wire logic        src_ready,
    input  wire logic        dst_ready,
    input  wire logic [7:0]  src_data,
    output logic             src_rd_q,
    output logic      [3:0]  src_sel_q,
    output logic             dst_wr_q,
    output logic      [3:0]  dst_sel_q,
    output logic      [7:0]  wr_data_q,
    output logic             chk_wr_q,
    output logic      [15:0] expanded_ram_addr_q,
    output logic             engine_irq_q
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0]  cr_q;
    logic [7:0]  cg_q;
    logic [7:0]  path_q;
    logic [7:0]  tcon_q [2];
    sdt_state_t  st_q;
    logic        en_q;
    logic        start_q;
    logic        dcf_q;
    logic        loop_q;
    logic [3:0]  src_f;
    logic [3:0]  dst_f;
    logic        wr_cr;
    logic        wr_cg;
    logic        wr_ds;
    logic        hw_set;
    logic        sw_set;
    logic        launch;
    logic        path_ok;
    logic        mem_use;
    logic        end_evt;
    logic        div_tick;
    logic [1:0]  tm_tick;
    logic [1:0]  tm_wrap;
    logic [1:0]  dma_tick;
    logic [15:0] cur_w [2];
    logic [15:0] rel_w [2];
    logic [7:0]  rd_mux;

    assign en_q    = cr_q[CR_EN];
    assign start_q = cr_q[CR_START];
    assign dcf_q   = cr_q[CR_DCF];
    assign loop_q  = cg_q[CG_LOOP];
    assign src_f   = path_q[7:4];
    assign dst_f   = path_q[3:0];

    function automatic logic src_ok(input logic [3:0] c);
        return c inside {P_UART0, P_UART1, P_TW0, P_TW1, P_SPI,
                         P_ADC, P_EXPANDED_RAM};
    endfunction

    function automatic logic dst_ok(input logic [3:0] c);
        return c inside {P_UART0, P_UART1, P_TW0, P_TW1, P_SPI,
                         P_CHK, P_EXPANDED_RAM};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register decode
    assign wr_cr = sfr_wr && sfr_addr == SFR_DMA && sfr_page <= PG_CR_MAX;
    assign wr_cg = sfr_wr && sfr_addr == SFR_DMA && sfr_page == PG_CFG;
    assign wr_ds = sfr_wr && sfr_addr == SFR_DMA && sfr_page == PG_PATH;

    // Reserved codes and disabled sides never run
    assign path_ok = src_ok(src_f) && dst_ok(dst_f)
                  && !(src_f == P_EXPANDED_RAM && dst_f == P_EXPANDED_RAM);
    assign mem_use = src_f == P_EXPANDED_RAM || dst_f == P_EXPANDED_RAM;
    assign launch  = st_q == ST_IDLE && en_q && start_q && path_ok
                  && src_ready && dst_ready;
    assign end_evt = en_q && tm_wrap[0];

    always_comb begin
        unique case (cg_q[CG_TRG +: 2])
            TRG_INT2: hw_set = ext_irq2_event;
            TRG_KEY:  hw_set = keypad_irq_event;
            default:  hw_set = 1'b0;
        endcase
    end
    assign sw_set = wr_cr && sfr_wdata[CR_START];

    ////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cr_q <= RST_BYTE;
        end else begin
            if (wr_cr) begin
                cr_q[CR_EN]  <= sfr_wdata[CR_EN];
                cr_q[CR_DIE] <= sfr_wdata[CR_DIE];
            end
            if (en_q && hw_set) begin
                cr_q[CR_START] <= 1'b1;
            end else if (wr_cr) begin
                cr_q[CR_START] <= sfr_wdata[CR_START];
            end else if (end_evt && !loop_q) begin
                cr_q[CR_START] <= 1'b0;
            end
            if (end_evt) begin
                cr_q[CR_DCF] <= 1'b1;
            end else if (wr_cr && !sfr_wdata[CR_DCF]) begin
                cr_q[CR_DCF] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cg_q <= RST_BYTE;
        end else if (wr_cg) begin
            cg_q <= sfr_wdata & CG_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            path_q <= RST_BYTE;
        end else if (wr_ds) begin
            path_q <= sfr_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Transaction sequencer
    always_ff @(posedge core_clk) begin
        if (sys_rst || !en_q) begin
            st_q <= ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE:  if (launch) st_q <= ST_READ;
                ST_READ:  st_q <= ST_CAPT;
                ST_CAPT:  st_q <= ST_WRITE;
                ST_WRITE: st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || !en_q) begin
            src_rd_q    <= 1'b0;
            dst_wr_q    <= 1'b0;
            chk_wr_q    <= 1'b0;
            src_sel_q   <= P_OFF;
            dst_sel_q   <= P_OFF;
            wr_data_q   <= RST_BYTE;
            expanded_ram_addr_q <= RST_WORD;
        end else begin
            src_rd_q <= launch;
            dst_wr_q <= st_q == ST_CAPT;
            chk_wr_q <= st_q == ST_CAPT && cg_q[CG_CRCW]
                     && dst_f != P_CHK;
            if (launch) begin
                src_sel_q   <= src_f;
                dst_sel_q   <= dst_f;
                expanded_ram_addr_q <= cur_w[1];
            end
            if (st_q == ST_CAPT) begin
                wr_data_q <= src_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Embedded timers
    sdt_div u_div (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .tick_q   (div_tick)
    );

    // Count advances per byte; address only when memory is used
    assign dma_tick[0] = st_q == ST_WRITE;
    assign dma_tick[1] = st_q == ST_WRITE && mem_use;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_tm
            logic pin_q;
            logic ext_q;
            logic clk_en;
            logic gate_ok;
            logic pin_in;
            logic ext_in;
            logic irq_in;
            logic gext_in;
            logic [7:0] base;
            logic [1:0] cks;
            logic [1:0] gat;

            assign pin_in  = i == 0 ? count_timer_pin : address_timer_pin;
            assign ext_in  = i == 0 ? timer2_ext_input_sel
                                    : timer3_ext_input_sel;
            assign gext_in = i == 0 ? timer3_ext_input_sel
                                    : timer2_ext_input_sel;
            assign irq_in  = i == 0 ? ext_irq0_event : ext_irq1_event;
            assign base    = i == 0 ? {4'h0, PG_CNT} : {4'h0, PG_ADR};
            assign cks     = tcon_q[i][TC_CKS +: 2];
            assign gat     = tcon_q[i][TC_GAT +: 2];

            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    pin_q <= 1'b0;
                    ext_q <= 1'b0;
                end else begin
                    pin_q <= pin_in;
                    ext_q <= ext_in;
                end
            end

            // Falling edges count for pin and external sources
            always_comb begin
                unique case (cks)
                    CKS_DIV: clk_en = div_tick;
                    CKS_PIN: clk_en = pin_q && !pin_in;
                    CKS_SYS: clk_en = 1'b1;
                    default: clk_en = ext_q && !ext_in;
                endcase
                unique case (gat)
                    GAT_NONE: gate_ok = 1'b1;
                    GAT_IRQ:  gate_ok = !irq_in;
                    GAT_INT2: gate_ok = !ext_irq2_event;
                    default:  gate_ok = gext_in;
                endcase
            end

            assign tm_tick[i] = en_q ? dma_tick[i]
                : tcon_q[i][TC_TR] && gate_ok && clk_en;

            sdt_timer u_tm (
                .core_clk (core_clk),
                .sys_rst  (sys_rst),
                .tick     (tm_tick[i]),
                .reload   (i == 1 && end_evt),
                .wr_cu_lo (sfr_wr && sfr_page == base[3:0]
                           && sfr_addr == SFR_CU_LO),
                .wr_cu_hi (sfr_wr && sfr_page == base[3:0]
                           && sfr_addr == SFR_CU_HI),
                .wr_rl_lo (sfr_wr && sfr_page == base[3:0]
                           && sfr_addr == SFR_RL_LO),
                .wr_rl_hi (sfr_wr && sfr_page == base[3:0]
                           && sfr_addr == SFR_RL_HI),
                .wdata    (sfr_wdata),
                .cur_q    (cur_w[i]),
                .rel_q    (rel_w[i]),
                .wrap     (tm_wrap[i])
            );

            // Overflow flag only in timer mode; set wins over clear
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    tcon_q[i] <= RST_BYTE;
                end else begin
                    if (sfr_wr && sfr_page == base[3:0]
                        && sfr_addr == SFR_TCON) begin
                        tcon_q[i] <= sfr_wdata & TC_MASK;
                    end
                    if (!en_q && tm_wrap[i]) begin
                        tcon_q[i][TC_TF] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Read data and shared interrupt request
    always_comb begin
        rd_mux = RST_BYTE;
        if (sfr_addr == SFR_DMA && sfr_page <= PG_CR_MAX) begin
            rd_mux = cr_q & CR_MASK;
        end else if (sfr_addr == SFR_DMA && sfr_page == PG_CFG) begin
            rd_mux = cg_q;
        end else if (sfr_addr == SFR_DMA && sfr_page == PG_PATH) begin
            rd_mux = path_q;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (sfr_page == (k == 0 ? PG_CNT : PG_ADR)) begin
                    unique case (sfr_addr)
                        SFR_TCON:  rd_mux = tcon_q[k];
                        SFR_RL_LO: rd_mux = rel_w[k][7:0];
                        SFR_RL_HI: rd_mux = rel_w[k][15:8];
                        SFR_CU_LO: rd_mux = cur_w[k][7:0];
                        SFR_CU_HI: rd_mux = cur_w[k][15:8];
                        default:   rd_mux = RST_BYTE;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sfr_rdata_q  <= RST_BYTE;
            engine_irq_q <= 1'b0;
        end else begin
            if (sfr_rd) sfr_rdata_q <= rd_mux;
            engine_irq_q <= global_engine_irq_enable
                && ((dcf_q && cr_q[CR_DIE])
                || (tcon_q[0][TC_TF] && tcon_q[0][TC_IE])
                || (tcon_q[1][TC_TF] && tcon_q[1][TC_IE]));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    start_launch_a: assert property (
        launch |=> st_q == ST_READ && src_rd_q ##2 dst_wr_q)
        else $error("launch did not run a transaction");
    hw_trig_a: assert property (
        en_q && cg_q[CG_TRG +: 2] == TRG_KEY && keypad_irq_event
        |=> start_q)
        else $error("hardware trigger did not set start");
    end_clear_a: assert property (
        end_evt && !loop_q && !hw_set && !wr_cr |=> !start_q)
        else $error("start not cleared at end of transfer");
    suspend_a: assert property (
        st_q == ST_READ && !start_q && en_q && !wr_cr
        |=> st_q == ST_CAPT)
        else $error("suspend cut a transaction short");
    stop_a: assert property (
        !en_q |=> st_q == ST_IDLE && !src_rd_q && !dst_wr_q)
        else $error("disable did not stop the engine");
    flag_set_a: assert property (
        end_evt |=> dcf_q ##1 (engine_irq_q
            || !$past(global_engine_irq_enable) || !$past(cr_q[CR_DIE])))
        else $error("completion flag or request missing");
    flag_hold_a: assert property (
        dcf_q && !(wr_cr && !sfr_wdata[CR_DCF]) |=> dcf_q)
        else $error("completion flag dropped");
    loop_keep_a: assert property (
        end_evt && loop_q && !wr_cr
        |=> start_q && cur_w[1] == $past(rel_w[1]))
        else $error("loop mode did not reload");
    count_step_a: assert property (
        st_q == ST_WRITE && en_q && cur_w[0] != ALL_ONES
        |=> cur_w[0] == $past(cur_w[0]) + 16'h0001)
        else $error("count did not advance by one");
    no_m2m_a: assert property (
        st_q == ST_IDLE && src_f == P_EXPANDED_RAM && dst_f == P_EXPANDED_RAM
        |=> st_q == ST_IDLE)
        else $error("memory to memory transfer started");
    copy_chk_a: assert property (
        dst_wr_q |-> chk_wr_q == ($past(cg_q[CG_CRCW])
            && dst_sel_q != P_CHK))
        else $error("checksum copy mismatch");
    hold_susp_a: assert property (
        en_q && st_q == ST_IDLE && !sfr_wr |=> $stable(cur_w[0])
            && $stable(cur_w[1]))
        else $error("pointers moved while suspended");
endmodule // sdt_dma_top

// >>> logic/sdt_pkg.sv
package sdt_pkg;
    // Register addresses and pages
    localparam logic [7:0] SFR_DMA   = 8'h94;
    localparam logic [7:0] SFR_TCON  = 8'hc8;
    localparam logic [7:0] SFR_RL_LO = 8'hca;
    localparam logic [7:0] SFR_RL_HI = 8'hcb;
    localparam logic [7:0] SFR_CU_LO = 8'hcc;
    localparam logic [7:0] SFR_CU_HI = 8'hcd;
    localparam logic [3:0] PG_CR_MAX = 4'h7;
    localparam logic [3:0] PG_CFG    = 4'h8;
    localparam logic [3:0] PG_PATH   = 4'h9;
    localparam logic [3:0] PG_CNT    = 4'h3;
    localparam logic [3:0] PG_ADR    = 4'h4;
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] ALL_ONES = 16'hffff;
    // Field positions
    localparam int CR_EN    = 3;
    localparam int CR_START = 2;
    localparam int CR_DIE   = 1;
    localparam int CR_DCF   = 0;
    localparam int CG_CRCW  = 5;
    localparam int CG_TRG   = 2;
    localparam int CG_LOOP  = 0;
    localparam int TC_TF    = 7;
    localparam int TC_CKS   = 4;
    localparam int TC_IE    = 3;
    localparam int TC_TR    = 2;
    localparam int TC_GAT   = 0;
    localparam logic [7:0] CR_MASK = 8'h0f;
    localparam logic [7:0] CG_MASK = 8'hed;
    localparam logic [7:0] TC_MASK = 8'hbf;
    // Trigger, clock and gate codes
    localparam logic [1:0] TRG_SW   = 2'h0;
    localparam logic [1:0] TRG_INT2 = 2'h1;
    localparam logic [1:0] TRG_KEY  = 2'h3;
    localparam logic [1:0] CKS_DIV  = 2'h0;
    localparam logic [1:0] CKS_PIN  = 2'h1;
    localparam logic [1:0] CKS_SYS  = 2'h2;
    localparam logic [1:0] GAT_NONE = 2'h0;
    localparam logic [1:0] GAT_IRQ  = 2'h1;
    localparam logic [1:0] GAT_INT2 = 2'h2;
    // Path codes
    localparam logic [3:0] P_OFF   = 4'h0;
    localparam logic [3:0] P_UART0 = 4'h1;
    localparam logic [3:0] P_UART1 = 4'h2;
    localparam logic [3:0] P_TW0   = 4'h5;
    localparam logic [3:0] P_TW1   = 4'h6;
    localparam logic [3:0] P_SPI   = 4'h7;
    localparam logic [3:0] P_ADC   = 4'h9;
    localparam logic [3:0] P_CHK   = 4'hd;
    localparam logic [3:0] P_EXPANDED_RAM  = 4'hf;
    localparam int SYS_DIV = 12;
    typedef enum logic [1:0] {
        ST_IDLE, ST_READ, ST_CAPT, ST_WRITE
    } sdt_state_t;
endpackage

// >>> logic/sdt_div.sv
`timescale 1ns/1ps
module sdt_div
    import sdt_pkg::*;
#(
    parameter int DIV = SYS_DIV
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    output logic      tick_q
);
    logic [$clog2(DIV)-1:0] cnt_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (cnt_q == $bits(cnt_q)'(DIV - 1));
            if (cnt_q == $bits(cnt_q)'(DIV - 1)) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule // sdt_div

// >>> logic/sdt_timer.sv
`timescale 1ns/1ps
module sdt_timer
    import sdt_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        tick,
    input  wire logic        reload,
    input  wire logic        wr_cu_lo,
    input  wire logic        wr_cu_hi,
    input  wire logic        wr_rl_lo,
    input  wire logic        wr_rl_hi,
    input  wire logic [7:0]  wdata,
    output logic      [15:0] cur_q,
    output logic      [15:0] rel_q,
    output logic             wrap
);
    assign wrap = tick && (cur_q == ALL_ONES);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rel_q <= RST_WORD;
        end else begin
            if (wr_rl_lo) rel_q[7:0] <= wdata;
            if (wr_rl_hi) rel_q[15:8] <= wdata;
        end
    end

    // Auto-reload on wrap or forced reload, else CPU write, else count
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cur_q <= RST_WORD;
        end else if (wrap || reload) begin
            cur_q <= rel_q;
        end else if (wr_cu_lo || wr_cu_hi) begin
            if (wr_cu_lo) cur_q[7:0] <= wdata;
            if (wr_cu_hi) cur_q[15:8] <= wdata;
        end else if (tick) begin
            cur_q <= cur_q + 16'h0001;
        end
    end
endmodule // sdt_timer

// >>> tb/sdt_periph.sv
`timescale 1ns/1ps
module sdt_periph (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       stall,
    input  wire logic       src_rd_q,
    input  wire logic       dst_wr_q,
    input  wire logic       chk_wr_q,
    input  wire logic [7:0] wr_data_q,
    output logic            src_ready,
    output logic            dst_ready,
    output logic      [7:0] src_data,
    output logic      [7:0] last_wr_q,
    output logic      [7:0] wr_cnt_q,
    output logic      [7:0] chk_cnt_q
);
    logic [7:0] nxt_q;
    logic       vld_q;
    assign src_ready = !stall;
    assign dst_ready = !stall;
    // Byte only valid in the cycle after the read strobe
    assign src_data  = vld_q ? nxt_q : ~nxt_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            nxt_q <= 8'ha5;
            vld_q <= 1'b0;
        end else begin
            vld_q <= src_rd_q;
            if (vld_q) nxt_q <= nxt_q + 8'h01;
        end
    end
    // Count destination and checksum writes
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_cnt_q  <= 8'h00;
            chk_cnt_q <= 8'h00;
            last_wr_q <= 8'h00;
        end else begin
            if (dst_wr_q) wr_cnt_q <= wr_cnt_q + 8'h01;
            if (dst_wr_q) last_wr_q <= wr_data_q;
            if (chk_wr_q) chk_cnt_q <= chk_cnt_q + 8'h01;
        end
    end
endmodule // sdt_periph

// >>> tb/sdt_dma_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
    num_errors++; $display("MISMATCH %s exp=%h got=%h", nm, exp, got); end end
module sdt_dma_top_tb
    import sdt_pkg::*;
;
    logic        core_clk, sys_rst, sfr_wr, sfr_rd, glb_en, stall;
    logic        irq0, irq1, irq2, key, t2x, t3x, p5, p6;
    logic [3:0]  sfr_page, src_sel_q, dst_sel_q;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_q, src_data, wr_data_q;
    logic [7:0]  last_wr, n_wr, n_chk, base;
    logic [15:0] expanded_ram_addr_q;
    logic        src_rd_q, dst_wr_q, chk_wr_q, engine_irq_q, s_rdy, d_rdy;
    int          num_errors = 0;
    int          checks = 0;
    sdt_dma_top u_sdt_dma_top (.core_clk(core_clk), .sys_rst(sys_rst),
        .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
        .global_engine_irq_enable(glb_en), .ext_irq0_event(irq0),
        .ext_irq1_event(irq1), .ext_irq2_event(irq2),
        .keypad_irq_event(key), .timer2_ext_input_sel(t2x),
        .timer3_ext_input_sel(t3x), .count_timer_pin(p5),
        .address_timer_pin(p6), .src_ready(s_rdy), .dst_ready(d_rdy),
        .src_data(src_data), .src_rd_q(src_rd_q), .src_sel_q(src_sel_q),
        .dst_wr_q(dst_wr_q), .dst_sel_q(dst_sel_q), .wr_data_q(wr_data_q),
        .chk_wr_q(chk_wr_q), .expanded_ram_addr_q(expanded_ram_addr_q),
        .engine_irq_q(engine_irq_q));
    sdt_periph u_sdt_periph (.core_clk(core_clk), .sys_rst(sys_rst),
        .stall(stall), .src_rd_q(src_rd_q), .dst_wr_q(dst_wr_q),
        .chk_wr_q(chk_wr_q), .wr_data_q(wr_data_q), .src_ready(s_rdy),
        .dst_ready(d_rdy), .src_data(src_data), .last_wr_q(last_wr),
        .wr_cnt_q(n_wr), .chk_cnt_q(n_chk));
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] p, input logic [7:0] a,
                      input logic [7:0] d);
        sfr_page <= p;
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic cr(input logic [3:0] p, input logic [7:0] a,
                      input logic [7:0] exp, input string nm);
        sfr_page <= p;
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        @(posedge core_clk);
        `CHK(nm, exp, sfr_rdata_q)
    endtask
    task automatic wait_done();
        for (int i = 0; i < 300 && engine_irq_q !== 1'b1; i++) begin
            @(posedge core_clk);
        end
        `CHK("irq", 1'b1, engine_irq_q)
        wr(4'h0, SFR_DMA, 8'h0a);
    endtask
    task automatic final_report();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        cr(4'h0, SFR_DMA, 8'h00, "ctrl");
        cr(PG_CNT, SFR_CU_HI, 8'h00, "cnt");
        cr(4'h0, 8'h33, 8'h00, "unmapped");
    endtask
    task automatic t_sw_xfer();
        wr(PG_PATH, SFR_DMA, {P_UART0, P_EXPANDED_RAM});
        wr(PG_CNT, SFR_CU_LO, 8'hfe);
        wr(PG_CNT, SFR_CU_HI, 8'hff);
        wr(PG_CNT, SFR_RL_LO, 8'hfe);
        wr(PG_CNT, SFR_RL_HI, 8'hff);
        wr(PG_ADR, SFR_CU_LO, 8'h10);
        wr(PG_ADR, SFR_RL_LO, 8'h10);
        wr(PG_CFG, SFR_DMA, 8'h20);
        glb_en <= 1'b1;
        wr(4'h0, SFR_DMA, 8'h0a);
        wr(4'h0, SFR_DMA, 8'h0e);
        for (int i = 0; i < 300 && engine_irq_q !== 1'b1; i++) begin
            @(posedge core_clk);
        end
        `CHK("bytes", 8'h02, n_wr)
        `CHK("copies", 8'h02, n_chk)
        `CHK("data", 8'ha6, last_wr)
        `CHK("addr", 16'h0011, expanded_ram_addr_q)
        cr(4'h0, SFR_DMA, 8'h0b, "done");
        cr(PG_CNT, SFR_CU_LO, 8'hfe, "cnt rld");
        cr(PG_ADR, SFR_CU_LO, 8'h10, "adr rld");
        cr(4'h0, SFR_DMA, 8'h0b, "sticky");
        wr(4'h0, SFR_DMA, 8'h0a);
        cr(4'h0, SFR_DMA, 8'h0a, "clr");
        `CHK("irq off", 1'b0, engine_irq_q)
    endtask
    task automatic t_hw_trig();
        base = n_wr;
        wr(PG_CFG, SFR_DMA, 8'h00);
        irq2 <= 1'b1;
        @(posedge core_clk);
        irq2 <= 1'b0;
        repeat (20) @(posedge core_clk);
        `CHK("sw only", base, n_wr)
        wr(PG_CFG, SFR_DMA, {4'h0, TRG_INT2, 2'h0});
        irq2 <= 1'b1;
        @(posedge core_clk);
        irq2 <= 1'b0;
        wait_done();
        `CHK("hw trig", base + 8'h02, n_wr)
        `CHK("no copy", 8'h02, n_chk)
        wr(PG_CFG, SFR_DMA, {4'h0, TRG_KEY, 2'h0});
        key <= 1'b1;
        @(posedge core_clk);
        key <= 1'b0;
        wait_done();
        `CHK("key trig", base + 8'h04, n_wr)
    endtask
    task automatic t_suspend();
        base = n_wr;
        stall <= 1'b1;
        wr(4'h0, SFR_DMA, 8'h0e);
        repeat (5) @(posedge core_clk);
        `CHK("not ready", base, n_wr)
        stall <= 1'b0;
        @(posedge core_clk);
        wr(4'h0, SFR_DMA, 8'h0a);
        repeat (20) @(posedge core_clk);
        `CHK("suspend", base + 8'h01, n_wr)
        cr(PG_CNT, SFR_CU_LO, 8'hff, "held");
        wr(4'h0, SFR_DMA, 8'h0e);
        wait_done();
        `CHK("resume", base + 8'h02, n_wr)
    endtask
    task automatic t_m2m();
        base = n_wr;
        wr(PG_PATH, SFR_DMA, {P_EXPANDED_RAM, P_EXPANDED_RAM});
        wr(4'h0, SFR_DMA, 8'h0e);
        repeat (30) @(posedge core_clk);
        `CHK("m2m", base, n_wr)
        wr(4'h0, SFR_DMA, 8'h00);
        wr(PG_PATH, SFR_DMA, 8'h00);
        cr(4'h0, SFR_DMA, 8'h00, "stopped");
    endtask
    task automatic t_loop();
        base = n_wr;
        wr(PG_CFG, SFR_DMA, 8'h01);
        wr(4'h0, SFR_DMA, 8'h0e);
        repeat (40) @(posedge core_clk);
        cr(4'h0, SFR_DMA, 8'h0f, "loop run");
        `CHK("loop more", 1'b1, n_wr - base > 8'h04)
        wr(4'h0, SFR_DMA, 8'h00);
        @(posedge core_clk);
        base = n_wr;
        repeat (10) @(posedge core_clk);
        `CHK("stop", base, n_wr)
    endtask
    task automatic t_timer();
        wr(PG_CNT, SFR_CU_LO, 8'hf0);
        wr(PG_CNT, SFR_CU_HI, 8'hff);
        wr(PG_CNT, SFR_TCON, 8'h2c);
        repeat (30) @(posedge core_clk);
        cr(PG_CNT, SFR_TCON, 8'hac, "tf set");
        `CHK("tm irq", 1'b1, engine_irq_q)
        irq0 <= 1'b1;
        wr(PG_CNT, SFR_TCON, 8'h2d);
        wr(PG_CNT, SFR_TCON, 8'h2d);
        wr(PG_CNT, SFR_CU_LO, 8'h40);
        repeat (10) @(posedge core_clk);
        cr(PG_CNT, SFR_CU_LO, 8'h40, "gated");
        cr(PG_CNT, SFR_TCON, 8'h2d, "tf clr");
        `CHK("tm irq off", 1'b0, engine_irq_q)
        irq0 <= 1'b0;
        wr(PG_CNT, SFR_TCON, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        final_report();
    end
    initial begin
        {sys_rst, sfr_wr, sfr_rd, glb_en, stall} = 5'h10;
        {irq0, irq1, irq2, key, t2x, t3x, p5, p6} = 8'h00;
        sfr_page = 4'h0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_sw_xfer();
        t_hw_trig();
        t_suspend();
        t_loop();
        t_m2m();
        t_timer();
        final_report();
    end
endmodule // sdt_dma_top_tb
